// ### mdlc_top.sv
// modem terminal-side and line-side control pin logic
`timescale 1ns/1ns
module mdlc_top #(
   parameter int BREAK_CYCLES = mdlc_pkg::BREAK_CYC,
   parameter int MAKE_CYCLES  = mdlc_pkg::MAKE_CYC,
   parameter int VSW_CYCLES   = mdlc_pkg::VSW_CYC
) (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      srst,
   // register port
   input  wire logic [mdlc_pkg::AW-1:0]   regAddr,
   input  wire logic [mdlc_pkg::DW-1:0]   regWrData,
   input  wire logic                      regWrStb,
   input  wire logic                      regRdStb,
   output logic      [mdlc_pkg::DW-1:0]   regRdData,
   // modem core side
   input  wire logic                      rxBitIn,
   input  wire logic                      rxBitStb,
   input  wire logic                      carrierValid,
   input  wire logic                      answerTone,
   input  wire logic                      txReady,
   input  wire logic [15:0]               memAddr,
   output logic                           txBitOut,
   output logic                           txBitValid,
   output logic                           cmdStatePulse,
   output logic                           initPulse,
   output logic                           fsk103Sel,
   output logic                           memOnChip,
   output logic [1:0]                     loopMode,
   // terminal pins
   input  wire logic                      txdIn,
   input  wire logic                      rtsN,
   input  wire logic                      dtrN,
   input  wire logic                      extTxTimingIn,
   output logic                           txClockOut,
   output logic                           rxClockOut,
   output logic                           rxdOut,
   output logic                           ctsN,
   output logic                           dsrN,
   output logic                           dcdN,
   output logic                           speedIndN,
   output logic                           maintenanceIndicatorN,
   output logic                           autoAnswerIndicatorN,
   input  wire logic                      localLoopbackN,
   input  wire logic                      remoteLoopbackN,
   // line pins
   input  wire logic                      ringN,
   input  wire logic                      switchHookIn,
   output logic                           hookControlOut,
   output logic                           auxRelayOut,
   // straps
   input  wire logic                      fskVariantStrap,
   input  wire logic                      dumbStrap,
   input  wire logic                      externalAccessStrap,
   // serial memory pins
   input  wire logic                      nvramDataIn,
   output logic                           nvramDataOut,
   output logic                           nvramDataOeN,
   output logic                           nvramClockOut,
   output logic                           nvramCeOut
);
   import mdlc_pkg::*;

   // =====================================================================
   // input synchronisers: three stages, accept when stages two and three agree
   logic [NIN-1:0] pinRaw;
   logic [NIN-1:0] s1_q, s2_q, s3_q, filt_q, filtPrev_q;
   logic [2:0]     settle_q;
   logic           settled;

   assign pinRaw = {nvramDataIn, extTxTimingIn, externalAccessStrap, dumbStrap,
                    fskVariantStrap, remoteLoopbackN, localLoopbackN, switchHookIn,
                    ringN, dtrN, rtsN, txdIn};

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_sync
         always_ff @(posedge core_clk) begin
            if (srst) begin
               s1_q[gi]       <= IN_RST[gi];
               s2_q[gi]       <= IN_RST[gi];
               s3_q[gi]       <= IN_RST[gi];
               filt_q[gi]     <= IN_RST[gi];
               filtPrev_q[gi] <= IN_RST[gi];
            end else begin
               s1_q[gi]       <= pinRaw[gi];
               s2_q[gi]       <= s1_q[gi];
               s3_q[gi]       <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) begin
                  filt_q[gi] <= s3_q[gi];
               end
               filtPrev_q[gi] <= filt_q[gi];
            end
         end
      end
   endgenerate

   // edges are ignored until the filters have seen real pin levels
   always_ff @(posedge core_clk) begin
      if (srst) begin
         settle_q <= 3'h0;
      end else if (settle_q != SETTLE_CYC) begin
         settle_q <= settle_q + 3'h1;
      end
   end
   assign settled = (settle_q == SETTLE_CYC);

   logic dumb, ringing, dtrRise, swHookEdge;
   assign dumb       = filt_q[I_DUMB];
   assign dtrRise    = settled && filt_q[I_DTR] && !filtPrev_q[I_DTR];
   assign swHookEdge = settled && (filt_q[I_SWHOOK] != filtPrev_q[I_SWHOOK]);
   // the external transmit clock is used as a level; its rises are found on txClockOut

   // =====================================================================
   // register file
   logic [DW-1:0] ctrl_q, div_q;
   logic [3:0]    nvram_q;
   logic          cmdEvt_q, initEvt_q;
   logic          wrOk, statusRd;
   logic          syncMode;
   logic [1:0]    dtrOpt, rate;

   assign wrOk     = regWrStb && !dumb;
   assign statusRd = regRdStb && (regAddr == REG_STATUS);
   assign syncMode = ctrl_q[C_SYNC];
   assign dtrOpt   = ctrl_q[C_DTROPT +: 2];
   assign rate     = ctrl_q[C_RATE +: 2];
   assign ringing  = !filt_q[I_RING] && !ctrl_q[C_LEASED];

   // terminal-ready drop (dtrN rising) under option 3 reloads configuration
   always_ff @(posedge core_clk) begin
      if (srst || (dtrRise && dtrOpt == DTR_D3)) begin
         ctrl_q <= CTRL_RST;
         div_q  <= DIV_RST;
      end else if (wrOk && regAddr == REG_CTRL) begin
         ctrl_q <= regWrData;
      end else if (wrOk && regAddr == REG_DIV) begin
         div_q <= regWrData;
      end
   end

   // memory pins are driven by software, bit by bit
   always_ff @(posedge core_clk) begin
      if (srst) begin
         nvram_q <= 4'h0;
      end else if (wrOk && regAddr == REG_NVRAM) begin
         nvram_q <= regWrData[3:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         nvramClockOut <= 1'b0;
         nvramDataOut  <= 1'b0;
         nvramDataOeN  <= 1'b1;
         nvramCeOut    <= 1'b0;
      end else begin
         nvramClockOut <= nvram_q[0];
         nvramDataOut  <= nvram_q[1];
         nvramDataOeN  <= !nvram_q[2];
         nvramCeOut    <= nvram_q[3];
      end
   end

   // sticky events: a new event beats a clearing read in the same cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmdEvt_q  <= 1'b0;
         initEvt_q <= 1'b0;
      end else begin
         if (dtrRise && (dtrOpt == DTR_D2 || dtrOpt == DTR_D1)) begin
            cmdEvt_q <= 1'b1;
         end else if (statusRd) begin
            cmdEvt_q <= 1'b0;
         end
         if (dtrRise && dtrOpt == DTR_D3) begin
            initEvt_q <= 1'b1;
         end else if (statusRd) begin
            initEvt_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmdStatePulse <= 1'b0;
         initPulse     <= 1'b0;
      end else begin
         cmdStatePulse <= dtrRise && dtrOpt != DTR_D0 && dtrOpt != DTR_D3;
         initPulse     <= dtrRise && dtrOpt == DTR_D3;
      end
   end

   // =====================================================================
   // voice/data state and switch-hook toggle
   logic        voice_q;
   logic [31:0] vswCnt_q;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         voice_q  <= 1'b0;
         vswCnt_q <= 32'h0;
      end else if (wrOk && regAddr == REG_VOICE) begin
         voice_q  <= regWrData[0];
         vswCnt_q <= 32'(VSW_CYCLES);
      end else begin
         if (vswCnt_q != 32'h0) begin
            vswCnt_q <= vswCnt_q - 32'h1;
         end else if (swHookEdge) begin
            voice_q <= !voice_q;
         end
      end
   end

   // =====================================================================
   // pulse dialing engine
   mdlc_dial_t  dial_q;
   logic [3:0]  pulses_q;
   logic [31:0] dialCnt_q;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         dial_q    <= DIAL_IDLE;
         pulses_q  <= 4'h0;
         dialCnt_q <= 32'h0;
      end else begin
         case (dial_q)
            DIAL_IDLE: begin
               if (wrOk && regAddr == REG_DIAL && regWrData[3:0] != 4'h0) begin
                  pulses_q  <= regWrData[3:0];
                  dialCnt_q <= 32'(BREAK_CYCLES);
                  dial_q    <= DIAL_BREAK;
               end
            end
            DIAL_BREAK: begin
               if (dialCnt_q <= 32'h1) begin
                  dialCnt_q <= 32'(MAKE_CYCLES);
                  pulses_q  <= pulses_q - 4'h1;
                  dial_q    <= DIAL_MAKE;
               end else begin
                  dialCnt_q <= dialCnt_q - 32'h1;
               end
            end
            DIAL_MAKE: begin
               if (dialCnt_q > 32'h1) begin
                  dialCnt_q <= dialCnt_q - 32'h1;
               end else if (pulses_q != 4'h0) begin
                  dialCnt_q <= 32'(BREAK_CYCLES);
                  dial_q    <= DIAL_BREAK;
               end else begin
                  dial_q <= DIAL_IDLE;
               end
            end
            default: begin
               dial_q <= DIAL_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // line, handshake and indicator outputs
   logic offHook, autoAnsEff, higherRate;
   logic [1:0] loopSel;

   assign offHook    = !hookControlOut;
   assign autoAnsEff = ctrl_q[C_AUTOANS] && (dtrOpt != DTR_D2 || !filt_q[I_DTR]);
   assign higherRate = ctrl_q[C_FAMILY] ? (rate == RATE_1200) : (rate == RATE_2400);
   // 1: analog local, 2: remote, 3: digital local
   assign loopSel    = {!filt_q[I_RLB], !filt_q[I_LLB]};

   always_ff @(posedge core_clk) begin
      if (srst) begin
         hookControlOut        <= 1'b1;
         auxRelayOut           <= 1'b0;
         ctsN                  <= 1'b1;
         dsrN                  <= 1'b1;
         dcdN                  <= 1'b1;
         speedIndN             <= 1'b1;
         maintenanceIndicatorN <= 1'b1;
         autoAnswerIndicatorN  <= 1'b1;
         loopMode              <= 2'h0;
      end else begin
         hookControlOut <= (dial_q == DIAL_BREAK) ||
                           (dial_q == DIAL_IDLE && !ctrl_q[C_OFFHOOK]);
         auxRelayOut    <= voice_q;
         if (syncMode && ctrl_q[C_RTSFOLLOW]) begin
            ctsN <= !(txReady && !filt_q[I_RTS]);
         end else begin
            ctsN <= !txReady;
         end
         dsrN <= !(offHook && !voice_q && answerTone);
         if (syncMode || ctrl_q[C_DCDFOLLOW]) begin
            dcdN <= !carrierValid;
         end else begin
            dcdN <= 1'b0;
         end
         speedIndN             <= !higherRate;
         loopMode              <= settled ? loopSel : 2'h0;
         maintenanceIndicatorN <= !(loopMode != 2'h0 || ctrl_q[C_TEST]);
         autoAnswerIndicatorN  <= !(autoAnsEff || ringing);
      end
   end

   // fsk variant and memory routing follow the straps
   always_ff @(posedge core_clk) begin
      if (srst) begin
         fsk103Sel <= 1'b0;
         memOnChip <= 1'b0;
      end else begin
         fsk103Sel <= ctrl_q[C_FSK] && rate == RATE_300 && filt_q[I_FSKSTRAP];
         memOnChip <= filt_q[I_EXTACC] && memAddr >= ROM_LO && memAddr < ROM_HI;
      end
   end

   // =====================================================================
   // transmit clock and data sampling
   logic [DW-1:0] txCnt_q;
   logic          txClkNext;

   // internal clock: low for the first half period, rising half way, falling at wrap
   always_ff @(posedge core_clk) begin
      if (srst || !syncMode || txCnt_q >= div_q - 24'h1) begin
         txCnt_q <= 24'h0;
      end else begin
         txCnt_q <= txCnt_q + 24'h1;
      end
   end

   always_comb begin
      if (!syncMode) begin
         txClkNext = 1'b1;
      end else if (ctrl_q[C_EXTCLK]) begin
         txClkNext = filt_q[I_EXTCLK];
      end else begin
         txClkNext = (txCnt_q >= (div_q >> 1));
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         txClockOut <= 1'b1;
         txBitOut   <= 1'b1;
         txBitValid <= 1'b0;
      end else begin
         txClockOut <= txClkNext;
         // the terminal sees our edge; data is taken from the filtered pin
         txBitValid <= syncMode && txClkNext && !txClockOut;
         if (syncMode && txClkNext && !txClockOut) begin
            txBitOut <= filt_q[I_TXD];
         end
      end
   end

   // =====================================================================
   // receive data and clock
   logic [DW-1:0] rxCnt_q;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rxdOut     <= 1'b1;
         rxClockOut <= 1'b1;
         rxCnt_q    <= 24'h0;
      end else if (!syncMode) begin
         rxdOut     <= rxBitIn;
         rxClockOut <= 1'b1;
         rxCnt_q    <= 24'h0;
      end else if (rxBitStb) begin
         rxdOut     <= rxBitIn;
         rxClockOut <= 1'b0;
         rxCnt_q    <= div_q >> 1;
      end else if (rxCnt_q > 24'h1) begin
         rxCnt_q <= rxCnt_q - 24'h1;
      end else if (rxCnt_q == 24'h1) begin
         rxCnt_q    <= 24'h0;
         rxClockOut <= 1'b1;
      end
   end

   // =====================================================================
   // read port: data in the cycle after the strobe, zero elsewhere
   always_ff @(posedge core_clk) begin
      if (srst) begin
         regRdData <= 24'h0;
      end else if (regRdStb) begin
         case (regAddr)
            REG_CTRL:   regRdData <= ctrl_q;
            REG_DIV:    regRdData <= div_q;
            REG_VOICE:  regRdData <= {23'h0, voice_q};
            REG_DIAL:   regRdData <= {20'h0, pulses_q};
            REG_NVRAM:  regRdData <= {19'h0, filt_q[I_NVDATA], nvram_q};
            REG_STATUS: regRdData <= {14'h0, filt_q[I_FSKSTRAP], dumb,
                                      !filt_q[I_DTR], loopMode, initEvt_q,
                                      cmdEvt_q, dial_q != DIAL_IDLE,
                                      voice_q, ringing};
            default:    regRdData <= 24'h0;
         endcase
      end else begin
         regRdData <= 24'h0;
      end
   end

endmodule : mdlc_top

// ### mdlc_pkg.sv
// constants, register map and timing for the modem line-control pin block
package mdlc_pkg;
   localparam int DW = 24;
   localparam int AW = 4;
   // =====================================================================
   // register offsets
   localparam logic [AW-1:0] REG_CTRL   = 4'h0;
   localparam logic [AW-1:0] REG_DIAL   = 4'h1;
   localparam logic [AW-1:0] REG_VOICE  = 4'h2;
   localparam logic [AW-1:0] REG_NVRAM  = 4'h3;
   localparam logic [AW-1:0] REG_STATUS = 4'h4;
   localparam logic [AW-1:0] REG_DIV    = 4'h5;
   // =====================================================================
   // control fields
   localparam int C_SYNC = 0;
   localparam int C_DCDFOLLOW = 1;
   localparam int C_RTSFOLLOW = 2;
   localparam int C_DTROPT = 3;
   localparam int C_LEASED = 5;
   localparam int C_AUTOANS = 6;
   localparam int C_EXTCLK = 7;
   localparam int C_FSK = 8;
   localparam int C_FAMILY = 9;
   localparam int C_OFFHOOK = 10;
   localparam int C_TEST = 11;
   localparam int C_RATE = 12;
   localparam logic [DW-1:0] CTRL_RST = 24'h000000;
   localparam logic [DW-1:0] DIV_RST  = 24'h0196E6;
   localparam logic [1:0] RATE_300  = 2'h0;
   localparam logic [1:0] RATE_1200 = 2'h1;
   localparam logic [1:0] RATE_2400 = 2'h2;
   localparam logic [1:0] DTR_D3 = 2'h3;
   localparam logic [1:0] DTR_D2 = 2'h2;
   localparam logic [1:0] DTR_D1 = 2'h1;
   localparam logic [1:0] DTR_D0 = 2'h0;
   localparam logic [15:0] ROM_LO = 16'h2000;
   localparam logic [15:0] ROM_HI = 16'h4000;
   // =====================================================================
   // synchronised pin inputs
   localparam int NIN = 12;
   localparam int I_TXD = 0;
   localparam int I_RTS = 1;
   localparam int I_DTR = 2;
   localparam int I_RING = 3;
   localparam int I_SWHOOK = 4;
   localparam int I_LLB = 5;
   localparam int I_RLB = 6;
   localparam int I_FSKSTRAP = 7;
   localparam int I_DUMB = 8;
   localparam int I_EXTACC = 9;
   localparam int I_EXTCLK = 10;
   localparam int I_NVDATA = 11;
   localparam logic [NIN-1:0] IN_RST = 12'h07F;
   localparam logic [2:0] SETTLE_CYC = 3'h5;
   // =====================================================================
   // timing
   localparam int CLK_MHZ = 250;
   localparam int BREAK_MS = 60;
   localparam int MAKE_MS = 40;
   localparam int VSW_US = 200;
   localparam int BREAK_CYC = BREAK_MS * CLK_MHZ * 1000;
   localparam int MAKE_CYC = MAKE_MS * CLK_MHZ * 1000;
   localparam int VSW_CYC = VSW_US * CLK_MHZ;
   typedef enum logic [1:0] {DIAL_IDLE, DIAL_BREAK, DIAL_MAKE} mdlc_dial_t;
endpackage : mdlc_pkg

// ### mdlc_dte_model.sv
// terminal and memory side model for the line-control pin block
`timescale 1ns/1ns
module mdlc_dte_model (
   // clock and device pins
   input  wire logic core_clk,
   input  wire logic txClockOut,
   input  wire logic nvramDataOut,
   input  wire logic nvramDataOeN,
   output logic      txdIn,
   output logic      nvramDataIn
);
   logic [7:0] patQ = 8'hB4;
   logic       clkQ = 1'b1;
   // =============================================
   // transmit data, changed after each falling clock so it is settled at the rise
   always @(posedge core_clk) begin
      clkQ <= txClockOut;
      if (clkQ && !txClockOut) patQ <= {patQ[6:0], patQ[7] ^ patQ[5]};
   end
   assign txdIn = patQ[0];
   // a released memory data wire sits at its pull-up level
   assign nvramDataIn = nvramDataOeN ? 1'b1 : nvramDataOut;
endmodule : mdlc_dte_model

// ### mdlc_props.sv
// port assertions for the line-control pin block
`timescale 1ns/1ns
module mdlc_props (
   // watched ports
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        answerTone,
   input wire logic [15:0] memAddr,
   input wire logic        txBitValid,
   input wire logic        txClockOut,
   input wire logic        rxClockOut,
   input wire logic        rxdOut,
   input wire logic        cmdStatePulse,
   input wire logic        initPulse,
   input wire logic        memOnChip,
   input wire logic [1:0]  loopMode,
   input wire logic        dsrN,
   input wire logic        hookControlOut,
   input wire logic        auxRelayOut,
   input wire logic        maintenanceIndicatorN
);
   // =============================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   property p_rst_idle;
      disable iff (1'b0) srst |=> hookControlOut && dsrN && !auxRelayOut;
   endproperty
   property p_tx_rise;
      txBitValid |-> $rose(txClockOut);
   endproperty
   property p_rx_mid;
      $rose(rxClockOut) |-> $stable(rxdOut) && $past(rxdOut, 2) == rxdOut;
   endproperty
   property p_dsr;
      !dsrN |-> $past(answerTone) && !$past(hookControlOut);
   endproperty
   property p_rom;
      memOnChip |-> $past(memAddr) >= 16'h2000 && $past(memAddr) < 16'h4000;
   endproperty
   property p_maint;
      loopMode != 2'h0 |-> ##[0:1] !maintenanceIndicatorN;
   endproperty
   property p_cmd;
      cmdStatePulse |-> !initPulse ##1 !cmdStatePulse [*8];
   endproperty
   property p_init;
      initPulse |=> !initPulse;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle in reset");
   a_tx_rise: assert property (p_tx_rise) else $error("sample off clock rise");
   a_rx_mid: assert property (p_rx_mid) else $error("rx clock rise not mid-bit");
   a_dsr: assert property (p_dsr) else $error("data set ready without cause");
   a_rom: assert property (p_rom) else $error("on-chip outside range");
   a_maint: assert property (p_maint) else $error("loopback without indicator");
   a_cmd: assert property (p_cmd) else $error("command pulse malformed");
   a_init: assert property (p_init) else $error("init pulse too long");
   c_tx: cover property (txBitValid);
   c_dloop: cover property (loopMode == 2'h3);
   c_dsr: cover property (!dsrN);
endmodule : mdlc_props
bind mdlc_top mdlc_props mdlc_props_i (.core_clk, .srst, .answerTone, .memAddr, .txBitValid,
   .txClockOut, .rxClockOut, .rxdOut, .cmdStatePulse, .initPulse, .memOnChip, .loopMode,
   .dsrN, .hookControlOut, .auxRelayOut, .maintenanceIndicatorN);

// ### mdlc_top_tb.sv
// self-checking bench for the line-control pin block
`timescale 1ns/1ns
module mdlc_top_tb;
   import mdlc_pkg::*;
   // =============================================
   // signals
   logic        core_clk = 1'b0, srst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
   logic        rxBitIn = 1'b0, rxBitStb = 1'b0, carrierValid = 1'b0, answerTone = 1'b0;
   logic        txReady = 1'b1, rtsN = 1'b1, dtrN = 1'b1, extTxTimingIn = 1'b0;
   logic        localLoopbackN = 1'b1, remoteLoopbackN = 1'b1, ringN = 1'b1;
   logic        switchHookIn = 1'b0, fskVariantStrap = 1'b0, dumbStrap = 1'b0;
   logic        externalAccessStrap = 1'b0, linkRun = 1'b0;
   logic [3:0]  regAddr = 4'h0;
   logic [23:0] regWrData = 24'h0;
   logic [15:0] memAddr = 16'h0;
   logic [23:0] regRdData;
   logic [1:0]  loopMode;
   logic        txBitOut, txBitValid, cmdStatePulse, initPulse, fsk103Sel, memOnChip, txdIn;
   logic        txClockOut, rxClockOut, rxdOut, ctsN, dsrN, dcdN, speedIndN, nvramDataIn;
   logic        maintenanceIndicatorN, autoAnswerIndicatorN, hookControlOut, auxRelayOut;
   logic        nvramDataOut, nvramDataOeN, nvramClockOut, nvramCeOut;
   int          bad_count = 0, comparisons = 0, cyc = 0;
   logic [31:0] rs = 32'd53;
   mdlc_top #(.BREAK_CYCLES(20), .MAKE_CYCLES(10), .VSW_CYCLES(8)) mdlc_top_i (.*);
   mdlc_dte_model mdlc_dte_model_i (.core_clk, .txClockOut, .nvramDataOut, .nvramDataOeN,
      .txdIn, .nvramDataIn);
   always #2 core_clk = ~core_clk;
   // link clock runs only while a frame is on
   always begin
      #16;
      if (linkRun) extTxTimingIn <= ~extTxTimingIn;
   end
   always @(posedge core_clk) if (++cyc == 20000) begin
      bad_count++;
      give_verdict();
   end
   // =============================================
   // helpers
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs
   task automatic chk(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge core_clk);
      regWrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [23:0] e);
      @(posedge core_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      @(negedge core_clk);
      chk(regRdData === e, "read data");
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // =============================================
   // scenarios
   initial begin
      int n;
      int k;
      logic [15:0] a;
      logic [15:0] addrs [5];
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(negedge core_clk);
      chk(hookControlOut === 1'b1 && ctsN === 1'b1 && dcdN === 1'b1, "reset levels");
      repeat (30) begin
         settle(0);
         chk(txClockOut === 1'b1 && rxClockOut === 1'b1, "async clocks");
      end
      rd(REG_DIV, DIV_RST);
      rd(4'hF, 24'h0);
      wr(REG_DIV, 24'h10);
      for (int m = 0; m < 3; m++) begin
         wr(REG_CTRL, m == 2 ? 24'h5 : 24'(m << 1));
         for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            carrierValid <= i[0];
            rtsN <= i[1];
            settle(8);
            chk(dcdN === (m != 0 ? !i[0] : 1'b0), "carrier detect");
            chk(ctsN === (m == 2 ? i[1] : 1'b0), "clear to send");
         end
      end
      for (int i = 0; i < 8; i++) begin
         n = 0;
         do settle(0); while (txBitValid !== 1'b1 && ++n < 40);
         chk(txBitValid === 1'b1 && txBitOut === txdIn, "tx sample");
      end
      repeat (4) begin
         @(posedge core_clk);
         a = 16'(xs());
         rxBitIn <= a[7];
         rxBitStb <= 1'b1;
         @(posedge core_clk);
         rxBitStb <= 1'b0;
         @(negedge core_clk);
         chk(rxdOut === rxBitIn && rxClockOut === 1'b0, "rx bit");
         settle(9);
         chk(rxClockOut === 1'b1, "rx clock rise");
      end
      wr(REG_CTRL, 24'h81);
      linkRun <= 1'b1;
      k = 0;
      repeat (64) begin
         settle(0);
         if (txBitValid === 1'b1) k++;
      end
      linkRun <= 1'b0;
      chk(k >= 7 && k <= 9, "external clock samples");
      wr(REG_CTRL, 24'h400);
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk);
         answerTone <= i[0];
         settle(3);
         chk(dsrN === !i[0] && hookControlOut === 1'b0, "off-hook data set ready");
      end
      @(posedge core_clk);
      answerTone <= 1'b0;
      wr(REG_DIAL, 24'h2);
      k = 0;
      repeat (80) begin
         settle(0);
         if (hookControlOut === 1'b1) k++;
      end
      chk(k == 40, "dial break cycles");
      for (int o = 0; o < 4; o++) begin
         wr(REG_CTRL, 24'(o) << 3);
         dtrN <= 1'b0;
         settle(8);
         @(posedge core_clk);
         dtrN <= 1'b1;
         n = 0;
         k = 0;
         repeat (12) begin
            settle(0);
            n += int'(cmdStatePulse === 1'b1);
            k += int'(initPulse === 1'b1);
         end
         chk(n == int'(o == 1 || o == 2) && k == int'(o == 3), "terminal ready");
      end
      rd(REG_STATUS, 24'h18);
      rd(REG_STATUS, 24'h0);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         localLoopbackN <= !i[0];
         remoteLoopbackN <= !i[1];
         settle(8);
         chk(loopMode === 2'(i) && maintenanceIndicatorN === (i == 0), "loopback");
      end
      @(posedge core_clk);
      localLoopbackN <= 1'b1;
      remoteLoopbackN <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(REG_CTRL, i[1] ? (i[0] ? 24'h1200 : 24'h2100) : 24'h0100);
         fskVariantStrap <= i[0];
         settle(8);
         chk(fsk103Sel === (i[0] & !i[1]) && speedIndN === !i[1], "fsk and speed");
      end
      addrs = '{16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000, 16'h0};
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 5; i++) begin
            a = (i == 4) ? 16'(xs()) : addrs[i];
            @(posedge core_clk);
            externalAccessStrap <= s[0];
            memAddr <= a;
            settle(8);
            chk(memOnChip === (s[0] && a >= 16'h2000 && a < 16'h4000), "rom select");
         end
      end
      wr(REG_NVRAM, 24'hF);
      settle(2);
      chk(nvramClockOut === 1'b1 && nvramCeOut === 1'b1 && nvramDataOeN === 1'b0, "nvram");
      rd(REG_NVRAM, 24'h1F);
      wr(REG_NVRAM, 24'hD);
      settle(8);
      rd(REG_NVRAM, 24'h0D);
      @(posedge core_clk);
      switchHookIn <= 1'b1;
      settle(10);
      chk(auxRelayOut === 1'b1, "switch hook to voice");
      wr(REG_VOICE, 24'h0);
      switchHookIn <= 1'b0;
      settle(12);
      chk(auxRelayOut === 1'b0, "switch hook during command");
      for (int i = 0; i < 4; i++) begin
         wr(REG_CTRL, i[1] ? 24'h70 : (i[0] ? 24'h20 : 24'h0));
         ringN <= 1'b0;
         dtrN <= !(i == 3);
         settle(8);
         chk(autoAnswerIndicatorN === (i == 1 || i == 2), "ring indication");
      end
      @(posedge core_clk);
      dumbStrap <= 1'b1;
      settle(8);
      wr(REG_CTRL, 24'h0);
      rd(REG_CTRL, 24'h70);
      give_verdict();
   end
endmodule : mdlc_top_tb
